// ===== hdl/sair_defs.svh
// Constants of the safe analog I/O register map block: offsets,
// field positions, scaling figures and timing.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
//
// Function
// - Temperature module has resistance or thermocouple mode
// - Resistance mode maps nine input-class words
// - Thermocouple mode maps ten words, status, junction
// - Out of range: limits, open wire, short
// - Current module maps nine input-class words
// - Current status byte uses only its MSB
// - 4-20 mA scales to 0-16000 or 0-4095
// - 0-20 mA scales to 0-20000 counts
// - 0-25 mA scales to 0-25000 counts
// - Output module maps eight output-class words
// - Outputs take time-out state when updates stop
`ifndef SAIR_DEFS_SVH
`define SAIR_DEFS_SVH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define SAIR_ADDR_W 12
`define SAIR_REG_TEMP 2'h0
`define SAIR_REG_CUR 2'h1
`define SAIR_REG_OUT 2'h2
`define SAIR_REG_CFG 2'h3
`define SAIR_IDX_STAT 4'h8
`define SAIR_IDX_JUNC 4'h9
`define SAIR_CFG_MODE 4'h0
`define SAIR_CFG_CRNG 4'h1
`define SAIR_CFG_ORNG 4'h2
`define SAIR_CFG_OTMO 4'h3
`define SAIR_CFG_STAT 4'h4
`define SAIR_CFG_USER0 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAIR_CUR_STAT_BIT 7
`define SAIR_WARN_LSB 8

// ----------------------------------------------------------------
// Scaling, in microamps and counts
// ----------------------------------------------------------------
`define SAIR_LIVE_ZERO_UA 16'h0FA0
`define SAIR_SPAN_16K 16'h3E80
`define SAIR_SPAN_20K 16'h4E20
`define SAIR_SPAN_25K 16'h61A8
`define SAIR_K4095 16'h4186
`define SAIR_PCT_FULL 16'h2710

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SAIR_CLK_MHZ 100
`define SAIR_TMO_MS 100
`define SAIR_TMO_CYC (`SAIR_TMO_MS * `SAIR_CLK_MHZ * 1000)

`endif

// ===== hdl/sair_pkg.sv
// Types shared by the safe analog I/O register map block.
// Assumes sair_defs.svh is compiled alongside.
package sair_pkg;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SAIR_C4_16K,
        SAIR_C4_4095,
        SAIR_C0_20,
        SAIR_C0_25
    } sair_crange_t;

    typedef enum logic [1:0] {
        SAIR_TMO_HOLD,
        SAIR_TMO_MIN,
        SAIR_TMO_MAX,
        SAIR_TMO_USER
    } sair_tmo_t;

    // ------------------------------------------------------------
    // Buses and state
    // ------------------------------------------------------------
    typedef logic [7:0][15:0] sair_word8_t;
    typedef logic [7:0][1:0] sair_sel8_t;

    typedef struct packed {
        sair_word8_t temp_raw;
        logic [7:0] open_w;
        logic [7:0] short_w;
        logic [15:0] junc;
        sair_word8_t cur_ua;
    } sair_in_t;

    typedef struct packed {
        sair_in_t sync1;
        sair_in_t sync2;
        sair_word8_t temp_val;
        logic [15:0] temp_stat;
        logic [15:0] junc_val;
        sair_word8_t cur_val;
        logic [7:0] cur_stat;
        logic tc_mode;
        sair_sel8_t cur_rng;
        sair_sel8_t out_rng;
        sair_sel8_t out_tmo;
        sair_word8_t out_user;
        sair_word8_t out_cmd;
        sair_word8_t out_val;
        logic [31:0] tmo_cnt;
        logic timed_out;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sair_state_t;

endpackage

// ===== hdl/sair_top.sv
// Register map of three safe analog modules behind one APB slave:
// temperature inputs, current inputs and outputs with a time-out.
// Assumes field readings arrive asynchronously and are resampled.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
`include "sair_defs.svh"

module sair_top #(
    parameter logic [31:0] TMO_CYC = `SAIR_TMO_CYC,
    parameter logic signed [15:0] RES_LO = -16'sd2000,
    parameter logic signed [15:0] RES_HI = 16'sd8500,
    parameter logic signed [15:0] TC_LO = -16'sd2700,
    parameter logic signed [15:0] TC_HI = 16'sd18200,
    parameter logic signed [15:0] WARN_BAND = 16'sd100
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`SAIR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Temperature front end
    input wire sair_pkg::sair_word8_t temp_raw_i,
    input wire logic [7:0] temp_open_i,
    input wire logic [7:0] temp_short_i,
    input wire logic [15:0] junc_temp_i,
    // Current front end, readings in microamps
    input wire sair_pkg::sair_word8_t cur_ua_i,
    // Output channels
    output sair_pkg::sair_word8_t out_val_o,
    output sair_pkg::sair_sel8_t out_range_o,
    output logic out_timed_out_o,
    output logic tc_mode_o
);
    import sair_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] sair_clip(
        input logic [15:0] v,
        input logic [15:0] lim
    );
        begin
            sair_clip = (v > lim) ? lim : v;
        end
    endfunction

    // Live-zero ranges clamp below 4 mA to zero counts
    function automatic logic [15:0] sair_scale(
        input logic [15:0] ua,
        input sair_crange_t r
    );
        logic [15:0] t;
        logic [31:0] p;
        begin
            t = (ua < `SAIR_LIVE_ZERO_UA) ? 16'h0000
                : sair_clip(ua - `SAIR_LIVE_ZERO_UA, `SAIR_SPAN_16K);
            p = 32'(t) * 32'(`SAIR_K4095);
            case (r)
                SAIR_C4_16K: sair_scale = t;
                SAIR_C4_4095: sair_scale = p[31:16];
                SAIR_C0_20: sair_scale = sair_clip(ua, `SAIR_SPAN_20K);
                SAIR_C0_25: sair_scale = sair_clip(ua, `SAIR_SPAN_25K);
                default: sair_scale = 16'h0000;
            endcase
        end
    endfunction

    function automatic logic sair_cur_bad(
        input logic [15:0] ua,
        input sair_crange_t r
    );
        logic [15:0] top;
        begin
            top = `SAIR_SPAN_20K;
            if (r == SAIR_C0_25) begin
                top = `SAIR_SPAN_25K;
            end
            sair_cur_bad = (ua > top) ||
                ((r == SAIR_C4_16K || r == SAIR_C4_4095) &&
                 (ua < `SAIR_LIVE_ZERO_UA));
        end
    endfunction

    // Fault and warning share one limit pair chosen by the mode
    function automatic logic [1:0] sair_temp_chk(
        input logic signed [15:0] v,
        input logic tc,
        input logic opn,
        input logic shrt
    );
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        logic bad;
        logic warn;
        begin
            lo = tc ? TC_LO : RES_LO;
            hi = tc ? TC_HI : RES_HI;
            bad = opn || shrt || (v < lo) || (v > hi);
            warn = !bad && ((v < lo + WARN_BAND) ||
                            (v > hi - WARN_BAND));
            sair_temp_chk = {warn, bad};
        end
    endfunction

    function automatic logic [15:0] sair_tmo_val(
        input sair_tmo_t sel,
        input logic [15:0] held,
        input logic [15:0] user
    );
        begin
            case (sel)
                SAIR_TMO_HOLD: sair_tmo_val = held;
                SAIR_TMO_MIN: sair_tmo_val = 16'h0000;
                SAIR_TMO_MAX: sair_tmo_val = `SAIR_PCT_FULL;
                SAIR_TMO_USER: sair_tmo_val = user;
                default: sair_tmo_val = held;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sair_state_t st;
    sair_state_t next_st;

    logic setup;
    logic wr_go;
    logic [1:0] region;
    logic [3:0] idx;
    logic [2:0] ch;
    logic [1:0] tchk;
    logic [31:0] rd;
    logic err;

    assign setup = psel_i && !penable_i;
    assign wr_go = psel_i && penable_i && st.pready && pwrite_i &&
                   !st.pslverr;
    assign region = paddr_i[7:6];
    assign idx = paddr_i[5:2];
    assign ch = paddr_i[4:2];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        rd = 32'h0000_0000;
        err = 1'b0;
        tchk = 2'b00;

        // Two-flop resampling of the field side
        next_st.sync1.temp_raw = temp_raw_i;
        next_st.sync1.open_w = temp_open_i;
        next_st.sync1.short_w = temp_short_i;
        next_st.sync1.junc = junc_temp_i;
        next_st.sync1.cur_ua = cur_ua_i;
        next_st.sync2 = st.sync1;

        // Input readings and status
        next_st.junc_val = st.sync2.junc;
        for (int i = 0; i < 8; i++) begin
            next_st.temp_val[i] = st.sync2.temp_raw[i];
            tchk = sair_temp_chk(st.sync2.temp_raw[i], st.tc_mode,
                                 st.sync2.open_w[i],
                                 st.sync2.short_w[i]);
            next_st.temp_stat[i] = tchk[0];
            next_st.temp_stat[i + `SAIR_WARN_LSB] = tchk[1];
            next_st.cur_val[i] = sair_scale(st.sync2.cur_ua[i],
                sair_crange_t'(st.cur_rng[i]));
        end
        next_st.cur_stat = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (sair_cur_bad(st.sync2.cur_ua[i],
                             sair_crange_t'(st.cur_rng[i]))) begin
                next_st.cur_stat[`SAIR_CUR_STAT_BIT] = 1'b1;
            end
        end

        // Read decode, answered one cycle after setup
        if (paddr_i[`SAIR_ADDR_W-1:8] != '0 || paddr_i[1:0] != 2'b00) begin
            err = 1'b1;
        end else begin
            case (region)
                `SAIR_REG_TEMP: begin
                    if (idx < `SAIR_IDX_STAT) begin
                        rd = {16'h0000, st.temp_val[ch]};
                    end else if (idx == `SAIR_IDX_STAT) begin
                        rd = {16'h0000, st.temp_stat};
                    end else if (idx == `SAIR_IDX_JUNC && st.tc_mode) begin
                        rd = {16'h0000, st.junc_val};
                    end else begin
                        err = 1'b1;
                    end
                end
                `SAIR_REG_CUR: begin
                    if (idx < `SAIR_IDX_STAT) begin
                        rd = {16'h0000, st.cur_val[ch]};
                    end else if (idx == `SAIR_IDX_STAT) begin
                        rd = {24'h000000, st.cur_stat};
                    end else begin
                        err = 1'b1;
                    end
                end
                `SAIR_REG_OUT: begin
                    if (idx < `SAIR_IDX_STAT) begin
                        rd = {16'h0000, st.out_cmd[ch]};
                    end else begin
                        err = 1'b1;
                    end
                end
                `SAIR_REG_CFG: begin
                    case (idx)
                        `SAIR_CFG_MODE: rd = {31'h0, st.tc_mode};
                        `SAIR_CFG_CRNG: rd = {16'h0000, st.cur_rng};
                        `SAIR_CFG_ORNG: rd = {16'h0000, st.out_rng};
                        `SAIR_CFG_OTMO: rd = {16'h0000, st.out_tmo};
                        `SAIR_CFG_STAT: rd = {31'h0, st.timed_out};
                        default: begin
                            if (idx >= `SAIR_CFG_USER0) begin
                                rd = {16'h0000, st.out_user[ch]};
                            end else begin
                                err = 1'b1;
                            end
                        end
                    endcase
                end
                default: err = 1'b1;
            endcase
        end
        // Read-only words refuse writes
        if (pwrite_i && (region == `SAIR_REG_TEMP ||
                         region == `SAIR_REG_CUR ||
                         (region == `SAIR_REG_CFG &&
                          idx == `SAIR_CFG_STAT))) begin
            err = 1'b1;
        end

        next_st.pready = setup;
        if (setup) begin
            next_st.prdata = pwrite_i ? 32'h0000_0000 : rd;
            next_st.pslverr = err;
        end else if (st.pready) begin
            next_st.prdata = 32'h0000_0000;
            next_st.pslverr = 1'b0;
        end

        // Writes at the access edge
        if (wr_go) begin
            case (region)
                `SAIR_REG_OUT: next_st.out_cmd[ch] = pwdata_i[15:0];
                `SAIR_REG_CFG: begin
                    case (idx)
                        `SAIR_CFG_MODE: next_st.tc_mode = pwdata_i[0];
                        `SAIR_CFG_CRNG: next_st.cur_rng = pwdata_i[15:0];
                        `SAIR_CFG_ORNG: next_st.out_rng = pwdata_i[15:0];
                        `SAIR_CFG_OTMO: next_st.out_tmo = pwdata_i[15:0];
                        default: begin
                            if (idx >= `SAIR_CFG_USER0) begin
                                next_st.out_user[ch] = pwdata_i[15:0];
                            end
                        end
                    endcase
                end
                default: next_st.out_cmd = st.out_cmd;
            endcase
        end

        // Update watchdog: any output word write restarts it
        if (wr_go && region == `SAIR_REG_OUT) begin
            next_st.tmo_cnt = 32'h0000_0000;
            next_st.timed_out = 1'b0;
        end else if (st.tmo_cnt >= TMO_CYC - 32'h1) begin
            next_st.timed_out = 1'b1;
        end else begin
            next_st.tmo_cnt = st.tmo_cnt + 32'h1;
        end

        // Drive channels; time-out values replace commands
        for (int i = 0; i < 8; i++) begin
            if (next_st.timed_out) begin
                next_st.out_val[i] = sair_tmo_val(
                    sair_tmo_t'(st.out_tmo[i]), st.out_val[i],
                    st.out_user[i]);
            end else begin
                next_st.out_val[i] = next_st.out_cmd[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_o = st.prdata;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign out_val_o = st.out_val;
    assign out_range_o = st.out_rng;
    assign out_timed_out_o = st.timed_out;
    assign tc_mode_o = st.tc_mode;

endmodule

// ===== sim/sair_cpu.sv
// Controller CPU model: APB master issuing one transfer per call.
// Assumes xfer is entered just after a rising edge of clk_sys_i.
`timescale 1ns/10ps
module sair_cpu (
    // Clock
    input wire logic clk_sys_i,
    // APB master
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h0;
        pwdata_o = 32'h0;
    end
    // ------------------------------------------------------------
    // Transfer
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e,
        output logic ok);
        int n;
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_sys_i);
        penable_o <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge clk_sys_i);
            ok = (pready_i === 1'b1);
        end
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released address and data lines must not keep showing the last value
        paddr_o <= ~a;
        pwdata_o <= ~d;
        @(posedge clk_sys_i);
    endtask
endmodule

// ===== sim/sair_monitor.sv
// Checker of the safe analog register map: APB answer and watchdog.
// Assumes it is bound into sair_top and sees only that module's ports.
`timescale 1ns/10ps
`include "sair_defs.svh"
module sair_monitor #(
    parameter logic [31:0] TMO_CYC = 32'h32
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`SAIR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Outputs
    input wire sair_pkg::sair_word8_t out_val_o,
    input wire sair_pkg::sair_sel8_t out_range_o,
    input wire logic out_timed_out_o,
    input wire logic tc_mode_o
);
    import sair_pkg::*;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic setup;
    logic acc_wr;
    logic owr;
    logic [31:0] gap;
    assign setup = psel_i && !penable_i;
    assign acc_wr = psel_i && penable_i && pready_o && pwrite_i;
    assign owr = acc_wr && !pslverr_o && paddr_i[11:5] == 7'h04
        && paddr_i[1:0] == 2'h0;
    // Saturates so a long idle stretch never wraps back to zero
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || owr) begin
            gap <= 32'h0;
        end else if (gap != 32'hFFFFFFFF) begin
            gap <= gap + 32'h1;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    chk_ready_setup: assert property (setup |=> pready_o)
        else $error("no answer after setup");
    chk_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    chk_idle_quiet: assert property (!pready_o |->
        prdata_o == 32'h0 && !pslverr_o) else $error("bus not quiet");
    chk_junc_refused: assert property (setup && paddr_i == 12'h024
        && !tc_mode_o |=> pslverr_o) else $error("junction not refused");
    chk_high_refused: assert property (setup
        && paddr_i[11:8] != 4'h0 |=> pslverr_o) else $error("bad address ok");
    chk_mode_write: assert property (acc_wr && paddr_i == 12'h0C0
        |=> tc_mode_o == $past(pwdata_i[0])) else $error("mode not set");
    chk_range_write: assert property (acc_wr && paddr_i == 12'h0C8
        |=> out_range_o == $past(pwdata_i[15:0])) else $error("range bad");
    chk_out_follow: assert property (owr |-> ##2
        out_val_o[$past(paddr_i[4:2], 2)] == $past(pwdata_i[15:0], 2))
        else $error("output not following command");
    chk_tmo_clear: assert property (owr |=> !out_timed_out_o)
        else $error("time-out not cleared by write");
    chk_tmo_late: assert property (gap > TMO_CYC + 32'h2
        |-> out_timed_out_o) else $error("time-out missing");
    chk_tmo_early: assert property (out_timed_out_o
        |-> 33'(gap) + 33'h2 >= 33'(TMO_CYC))
        else $error("time-out too early");
    chk_cur_unused: assert property (pready_o && paddr_i == 12'h060
        |-> prdata_o[6:0] == 7'h0) else $error("unused status bits set");
    cover property (owr);
    cover property ($rose(out_timed_out_o));
    cover property (pready_o && pslverr_o);
endmodule

bind sair_top sair_monitor #(.TMO_CYC(TMO_CYC)) i_mon (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .out_val_o(out_val_o),
    .out_range_o(out_range_o),
    .out_timed_out_o(out_timed_out_o),
    .tc_mode_o(tc_mode_o)
);

// ===== sim/tb_top.sv
// Self-checking bench of sair_top with random field readings.
// Assumes sair_cpu as bus master and a shortened watchdog count.
`timescale 1ns/10ps
module tb_top;
    import sair_pkg::*;
    localparam logic [31:0] TMO = 32'h32;
    logic clk_sys_i, nrst_i, psel, penable, pwrite, pready, pslverr;
    logic tmo_o, tc_o;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    sair_word8_t temp_raw, cur_ua, out_val, cmd;
    sair_sel8_t out_rng;
    logic [7:0] t_open, t_short;
    logic [15:0] junc;
    int errors, checked;
    sair_cpu i_cpu (.clk_sys_i(clk_sys_i), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));
    sair_top #(.TMO_CYC(TMO)) i_dut (.clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .temp_raw_i(temp_raw), .temp_open_i(t_open),
        .temp_short_i(t_short), .junc_temp_i(junc), .cur_ua_i(cur_ua),
        .out_val_o(out_val), .out_range_o(out_rng),
        .out_timed_out_o(tmo_o), .tc_mode_o(tc_o));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int rnd(input int m);
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
        return int'(seed % 32'(m));
    endfunction
    function automatic logic [15:0] estat(input logic tc);
        logic [15:0] s;
        int v, lo, hi;
        s = 16'h0;
        lo = tc ? -2700 : -2000;
        hi = tc ? 18200 : 8500;
        for (int i = 0; i < 8; i++) begin
            v = int'($signed(temp_raw[i]));
            if (t_open[i] || t_short[i] || v < lo || v > hi) s[i] = 1'b1;
            else if (v < lo + 100 || v > hi - 100) s[i+8] = 1'b1;
        end
        return s;
    endfunction
    function automatic logic [15:0] ecur(input int u, input logic [1:0] r);
        int x;
        x = (u < 4000) ? 0 : (u > 20000 ? 16000 : u - 4000);
        case (r)
            2'h0: return 16'(x);
            2'h1: return 16'((x * 16774) >> 16);
            2'h2: return 16'(u > 20000 ? 20000 : u);
            default: return 16'(u > 25000 ? 25000 : u);
        endcase
    endfunction
    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] ex, input logic er);
        logic [31:0] q;
        logic e, ok;
        i_cpu.xfer(w, a, d, q, e, ok);
        if (!ok) begin
            errors++;
            test_done();
        end
        cmp($sformatf("err %h", a), 32'(er), 32'(e));
        if (!w) cmp($sformatf("rd %h", a), ex, q);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n, u;
        logic [7:0] cs;
        {nrst_i, temp_raw, cur_ua, t_open, t_short, junc} = '0;
        {errors, checked} = '0;
        seed = 32'h51ADD180;
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        cmp("out_val", 32'h0, 32'(out_val[0]));
        acc(0, 12'h0C0, 0, 32'h0, 0);
        acc(0, 12'h002, 0, 32'h0, 1);
        acc(0, 12'h100, 0, 32'h0, 1);
        $display("test reset done");
        for (int i = 0; i < 8; i++) temp_raw[i] <= 16'(rnd(10100) - 1800);
        temp_raw[1] <= 16'h2198;
        temp_raw[2] <= 16'hF862;
        t_open <= 8'h08;
        t_short <= 8'h10;
        junc <= 16'(rnd(65536));
        repeat (5) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) acc(0, 12'(4*i), 0, 32'(temp_raw[i]), 0);
        acc(0, 12'h020, 0, 32'(estat(0)), 0);
        acc(0, 12'h024, 0, 32'h0, 1);
        acc(1, 12'h000, 32'h1, 32'h0, 1);
        acc(1, 12'h0C0, 32'h1, 32'h0, 0);
        cmp("tc_mode", 32'h1, 32'(tc_o));
        acc(0, 12'h020, 0, 32'(estat(1)), 0);
        acc(0, 12'h024, 0, 32'(junc), 0);
        acc(0, 12'h028, 0, 32'h0, 1);
        $display("test temperature done");
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 8; i++) cur_ua[i] <= 16'(rnd(27000));
            cur_ua[0] <= 16'h0F9F;
            cur_ua[1] <= 16'h61A8;
            acc(1, 12'h0C4, 32'({8{2'(r)}}), 32'h0, 0);
            repeat (5) @(posedge clk_sys_i);
            cs = 8'h0;
            for (int i = 0; i < 8; i++) begin
                u = int'(cur_ua[i]);
                if (u > (r == 3 ? 25000 : 20000) || (r < 2 && u < 4000))
                    cs[7] = 1'b1;
                acc(0, 12'(64 + 4*i), 0, 32'(ecur(u, 2'(r))), 0);
            end
            acc(0, 12'h060, 0, 32'(cs), 0);
        end
        acc(0, 12'h064, 0, 32'h0, 1);
        $display("test current done");
        acc(1, 12'h0CC, 32'hE4E4, 32'h0, 0);
        u = rnd(65536);
        acc(1, 12'h0C8, 32'(u), 32'h0, 0);
        cmp("out_range", 32'(u), 32'(out_rng));
        for (int i = 0; i < 8; i++) acc(1, 12'(224 + 4*i), 5000, 0, 0);
        for (int i = 0; i < 8; i++) begin
            cmd[i] = 16'(rnd(10001));
            acc(1, 12'(128 + 4*i), 32'(cmd[i]), 32'h0, 0);
        end
        for (int i = 0; i < 8; i++) cmp("out_val", 32'(cmd[i]), 32'(out_val[i]));
        acc(0, 12'h09C, 0, 32'(cmd[7]), 0);
        acc(1, 12'h0A0, 32'h1, 32'h0, 1);
        acc(1, 12'h0D0, 32'h1, 32'h0, 1);
        for (n = 0; n < 400 && tmo_o !== 1'b1; n++) @(posedge clk_sys_i);
        if (tmo_o !== 1'b1) begin
            errors++;
            test_done();
        end
        repeat (2) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i += 4) begin
            cmp("tmo hold", 32'(cmd[i]), 32'(out_val[i]));
            cmp("tmo min", 32'h0, 32'(out_val[i+1]));
            cmp("tmo max", 32'h2710, 32'(out_val[i+2]));
            cmp("tmo user", 32'h1388, 32'(out_val[i+3]));
        end
        acc(0, 12'h0D0, 0, 32'h1, 0);
        acc(1, 12'h080, 32'h0064, 32'h0, 0);
        cmp("timed_out", 32'h0, 32'(tmo_o));
        $display("test output done");
        test_done();
    end
endmodule
